// [verilog/tcic_pkg.sv]
// Purpose: Constants, types and helpers of the 16-bit timer with capture
// Assumes: One system clock; software access arrives as select strobes
// Notes:   Output compare, single pulse and PWM outputs live elsewhere
//
// Overview of operation
// R1: Counter counts up through all 16 bits; period is 65536 prescaled ticks.
// R2: Writing count low byte or shadow low byte reloads counter to FFFCh.
// R3: Counter starts at FFFCh after reset; FFFCh is the only reload value.
// R4: Two read-only views of one count; shadow low access leaves wrap flag.
// R5: High byte read first buffers low byte until the low byte is read.
// R6: After a finished sequence, a lone low byte read returns live count.
// R7: Wrap from FFFFh to 0000h sets the wrap flag in every mode.
// R8: Wrap interrupt only when enabled and global mask clear; else pending.
// R9: Wrap flag clears on status read while set, then count low access.
// R10: Halt freezes counter; interrupt wake resumes, reset wake restarts.
// R11: Both clock select bits set choose the external clock pin.
// R12: External edge select picks rising or falling external clock edge.
// R13: External clock edges are synchronised to the system clock.
// R14: External clock leaves four system clock edges between active edges.
// R15: Two channels latch the count on active pin edge; latest kept.
// R16: Each channel has its own capture edge select bit.
// R17: Capture sets channel flag; one shared capture interrupt enable.
// R18: Capture interrupt only when enabled and global mask clear.
// R19: Capture flag clears on status read while set, then its low access.
// R20: Capture high read blocks capture and flag until capture low read.
// R21: In single pulse or PWM mode only channel two captures.
// R22: Capture pins are always wired; pin direction never gates their capture.
// R23: Clock codes 00, 01, 10 divide by 4, 2 and 8 respectively.
package tcic_pkg;

  // Counter values
  localparam logic [15:0] TCIC_CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] TCIC_CNT_TOP    = 16'hffff;
  localparam logic [15:0] TCIC_CAP_RST    = 16'h0000;

  // Clock select codes
  localparam logic [1:0] TCIC_CKS_DIV4 = 2'h0;
  localparam logic [1:0] TCIC_CKS_DIV2 = 2'h1;
  localparam logic [1:0] TCIC_CKS_DIV8 = 2'h2;
  localparam logic [1:0] TCIC_CKS_EXT  = 2'h3;

  // Last prescaler count of each divide ratio
  localparam logic [2:0] TCIC_DIV2_LAST = 3'h1;
  localparam logic [2:0] TCIC_DIV4_LAST = 3'h3;
  localparam logic [2:0] TCIC_DIV8_LAST = 3'h7;

  // Least system clocks between two external active edges
  localparam int TCIC_EXT_MIN_CLKS = 4;

  // Status byte bit positions
  localparam int TCIC_STS_CAP1_BIT = 7;
  localparam int TCIC_STS_WRAP_BIT = 5;
  localparam int TCIC_STS_CAP2_BIT = 4;

  // Software access selects
  typedef enum logic [3:0] {
    TCIC_SEL_CNT_HI  = 4'h0,
    TCIC_SEL_CNT_LO  = 4'h1,
    TCIC_SEL_SHD_HI  = 4'h2,
    TCIC_SEL_SHD_LO  = 4'h3,
    TCIC_SEL_STATUS  = 4'h4,
    TCIC_SEL_CAP1_HI = 4'h5,
    TCIC_SEL_CAP1_LO = 4'h6,
    TCIC_SEL_CAP2_HI = 4'h7,
    TCIC_SEL_CAP2_LO = 4'h8
  } tcic_sel_t;

  // Read sequence states
  typedef enum logic [1:0] {
    TCIC_RS_LIVE = 2'b01,
    TCIC_RS_HELD = 2'b10
  } tcic_rseq_t;

  // Edge detect on a synchronised level
  function automatic logic tcic_edge(input logic prev, input logic cur,
                                     input logic rise);
    tcic_edge = rise ? (cur & ~prev) : (prev & ~cur);
  endfunction

endpackage

// [verilog/tcic_cap_if.sv]
// Purpose: Link between timer core and one capture channel
// Assumes: All signals on the system clock
// Notes:   Strobes are one cycle wide
`timescale 1ns/100ps
interface tcic_cap_if;
  logic [15:0] count;
  logic        edge_rise;
  logic        enable;
  logic        rd_high;
  logic        rd_low;
  logic        stat_rd;
  logic        flag;
  logic [15:0] value;

  modport timer (output count, edge_rise, enable, rd_high, rd_low, stat_rd,
                 input  flag, value);
  modport chan  (input  count, edge_rise, enable, rd_high, rd_low, stat_rd,
                 output flag, value);
endinterface

// [verilog/tcic_capture.sv]
// Purpose: One input capture channel with flag and read lock
// Assumes: Pin is asynchronous to the system clock
// Notes:   Capture is seen two to three clocks after the pin edge
`timescale 1ns/100ps
module tcic_capture (
  input  wire logic   clk_sys_i,
  input  wire logic   rst_b_i,
  input  wire logic   ce_i,
  input  wire logic   pin_i,
  tcic_cap_if.chan    cap
);
  import tcic_pkg::*;

  logic [2:0]  sync_r;
  logic [2:0]  sync_nxt;
  logic [15:0] value_r;
  logic [15:0] value_nxt;
  logic        flag_r;
  logic        flag_nxt;
  logic        blocked_r;
  logic        blocked_nxt;
  logic        armed_r;
  logic        armed_nxt;
  logic        hit;

  // Pin synchroniser; stage 0 feeds only stage 1
  always_comb begin
    sync_nxt = {sync_r[1:0], pin_i};
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_r <= 3'h0;
    end else if (ce_i) begin
      sync_r <= sync_nxt;
    end
  end

  // Active edge, enabled and not locked by a high byte read
  assign hit = tcic_edge(sync_r[2], sync_r[1], cap.edge_rise) // R16 R22
               & cap.enable & ~blocked_r;                    // R20 R21

  // Capture value, flag and lock
  always_comb begin
    value_nxt   = value_r;
    flag_nxt    = flag_r;
    blocked_nxt = blocked_r;
    armed_nxt   = armed_r;
    if (cap.rd_high) begin
      blocked_nxt = 1'b1; // R20
    end
    if (cap.rd_low) begin
      blocked_nxt = 1'b0; // R20
    end
    if (cap.stat_rd && flag_r) begin
      armed_nxt = 1'b1; // R19
    end
    if (cap.rd_low && armed_r) begin
      flag_nxt  = 1'b0; // R19
      armed_nxt = 1'b0;
    end
    if (hit) begin
      value_nxt = cap.count; // R15
      flag_nxt  = 1'b1;      // R17
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      value_r   <= TCIC_CAP_RST;
      flag_r    <= 1'b0;
      blocked_r <= 1'b0;
      armed_r   <= 1'b0;
    end else if (ce_i) begin
      value_r   <= value_nxt;
      flag_r    <= flag_nxt;
      blocked_r <= blocked_nxt;
      armed_r   <= armed_nxt;
    end
  end

  assign cap.flag  = flag_r;
  assign cap.value = value_r;

  a_capture_latch: assert property (@(posedge clk_sys_i) // R15
    disable iff (!rst_b_i)
    ce_i && hit |=> flag_r && value_r == $past(cap.count))
    else $error("capture did not latch count");

  a_capture_locked: assert property (@(posedge clk_sys_i) // R20
    disable iff (!rst_b_i)
    ce_i && blocked_r && !cap.rd_low && !flag_r
    |=> !flag_r && $stable(value_r))
    else $error("capture taken while locked");

endmodule

// [verilog/tcic_timer.sv]
// Purpose: 16-bit free-running counter with prescaler, wrap flag and
//          two input capture channels
// Assumes: Software access is one-cycle select strobes on the system clock
// Notes:   Read data appears on the edge after the read strobe
`timescale 1ns/100ps
module tcic_timer (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic             halt_i,
  input  wire logic             irq_mask_i,
  input  wire logic [1:0]       clock_select_field_i,
  input  wire logic             ext_edge_select_i,
  input  wire logic [1:0]       capture_edge_select_i,
  input  wire logic             wrap_irq_enable_i,
  input  wire logic             capture_irq_enable_i,
  input  wire logic             single_pulse_mode_i,
  input  wire logic             pwm_mode_i,
  input  wire logic             ext_clock_pin_i,
  input  wire logic             capture_pin_one_i,
  input  wire logic             capture_pin_two_i,
  input  wire logic             acc_rd_i,
  input  wire logic             acc_wr_i,
  input  tcic_pkg::tcic_sel_t   acc_sel_i,
  output logic [7:0]            rd_data_o,
  output logic [15:0]           count_o,
  output logic                  wrap_flag_o,
  output logic [1:0]            capture_flag_o,
  output logic                  timer_irq_o
);
  import tcic_pkg::*;

  logic [2:0]  ext_sync_r;
  logic [2:0]  ext_sync_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [2:0]  div_r;
  logic [2:0]  div_nxt;
  logic [2:0]  div_last;
  logic        ext_edge;
  logic        tick;
  logic        cnt_wr;
  logic        wrap_ev;
  tcic_rseq_t  rs_r;
  tcic_rseq_t  rs_nxt;
  logic [7:0]  lo_buf_r;
  logic [7:0]  lo_buf_nxt;
  logic [7:0]  rd_data_r;
  logic [7:0]  rd_data_nxt;
  logic        wrap_r;
  logic        wrap_nxt;
  logic        wrap_armed_r;
  logic        wrap_armed_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        rd_hi;
  logic        rd_lo;
  logic        stat_rd;
  logic        cnt_lo_acc;
  logic [7:0]  status_byte;

  tcic_cap_if cap1 ();
  tcic_cap_if cap2 ();

  // Decoded software accesses
  assign cnt_wr     = acc_wr_i & ((acc_sel_i == TCIC_SEL_CNT_LO) |
                                  (acc_sel_i == TCIC_SEL_SHD_LO));
  assign rd_hi      = acc_rd_i & ((acc_sel_i == TCIC_SEL_CNT_HI) |
                                  (acc_sel_i == TCIC_SEL_SHD_HI));
  assign rd_lo      = acc_rd_i & ((acc_sel_i == TCIC_SEL_CNT_LO) |
                                  (acc_sel_i == TCIC_SEL_SHD_LO));
  assign stat_rd    = acc_rd_i & (acc_sel_i == TCIC_SEL_STATUS);
  assign cnt_lo_acc = (acc_rd_i | acc_wr_i) &
                      (acc_sel_i == TCIC_SEL_CNT_LO); // R4 R9

  // External clock pin synchroniser; stage 0 feeds only stage 1
  always_comb begin
    ext_sync_nxt = {ext_sync_r[1:0], ext_clock_pin_i}; // R13
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_sync_r <= 3'h0;
    end else if (ce_i) begin
      ext_sync_r <= ext_sync_nxt;
    end
  end

  assign ext_edge = tcic_edge(ext_sync_r[2], ext_sync_r[1],
                              ext_edge_select_i); // R12

  // Prescaler ratio from the clock select field
  always_comb begin
    unique case (clock_select_field_i)
      TCIC_CKS_DIV2: div_last = TCIC_DIV2_LAST; // R23
      TCIC_CKS_DIV4: div_last = TCIC_DIV4_LAST; // R23
      TCIC_CKS_DIV8: div_last = TCIC_DIV8_LAST; // R23
      TCIC_CKS_EXT:  div_last = TCIC_DIV8_LAST;
    endcase
  end

  // Prescaler and free-running counter
  always_comb begin
    div_nxt = div_r;
    cnt_nxt = cnt_r;
    tick    = 1'b0;
    if (!halt_i) begin // R10
      if (clock_select_field_i == TCIC_CKS_EXT) begin
        tick = ext_edge; // R11
      end else if (div_r == div_last) begin
        tick    = 1'b1;
        div_nxt = 3'h0;
      end else begin
        div_nxt = div_r + 3'h1;
      end
    end
    if (tick) begin
      cnt_nxt = cnt_r + 16'h0001; // R1
    end
    if (cnt_wr) begin
      cnt_nxt = TCIC_CNT_RELOAD; // R2
      div_nxt = 3'h0;
    end
  end

  assign wrap_ev = tick & ~cnt_wr & (cnt_r == TCIC_CNT_TOP);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= TCIC_CNT_RELOAD; // R3
      div_r <= 3'h0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
    end
  end

  // High-then-low read sequence with low byte holding buffer
  always_comb begin
    rs_nxt     = rs_r;
    lo_buf_nxt = lo_buf_r;
    unique case (rs_r)
      TCIC_RS_LIVE: begin
        if (rd_hi) begin
          lo_buf_nxt = cnt_r[7:0]; // R5
          rs_nxt     = TCIC_RS_HELD;
        end
      end
      TCIC_RS_HELD: begin
        if (rd_lo) begin
          rs_nxt = TCIC_RS_LIVE; // R6
        end
      end
      default: rs_nxt = TCIC_RS_LIVE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rs_r     <= TCIC_RS_LIVE;
      lo_buf_r <= 8'h00;
    end else if (ce_i) begin
      rs_r     <= rs_nxt;
      lo_buf_r <= lo_buf_nxt;
    end
  end

  // Status byte as software sees it
  always_comb begin
    status_byte                    = 8'h00;
    status_byte[TCIC_STS_CAP1_BIT] = cap1.flag;
    status_byte[TCIC_STS_WRAP_BIT] = wrap_r;
    status_byte[TCIC_STS_CAP2_BIT] = cap2.flag;
  end

  // Read data mux, registered
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (acc_rd_i) begin
      unique case (acc_sel_i)
        TCIC_SEL_CNT_HI,
        TCIC_SEL_SHD_HI:  rd_data_nxt = cnt_r[15:8]; // R4
        TCIC_SEL_CNT_LO,
        TCIC_SEL_SHD_LO:  rd_data_nxt = (rs_r == TCIC_RS_HELD) ?
                                        lo_buf_r : cnt_r[7:0]; // R5 R6
        TCIC_SEL_STATUS:  rd_data_nxt = status_byte;
        TCIC_SEL_CAP1_HI: rd_data_nxt = cap1.value[15:8];
        TCIC_SEL_CAP1_LO: rd_data_nxt = cap1.value[7:0];
        TCIC_SEL_CAP2_HI: rd_data_nxt = cap2.value[15:8];
        TCIC_SEL_CAP2_LO: rd_data_nxt = cap2.value[7:0];
        default:          rd_data_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_r <= 8'h00;
    end else if (ce_i) begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // Wrap flag with two-step clear; a new wrap wins over the clear
  always_comb begin
    wrap_nxt       = wrap_r;
    wrap_armed_nxt = wrap_armed_r;
    if (stat_rd && wrap_r) begin
      wrap_armed_nxt = 1'b1; // R9
    end
    if (cnt_lo_acc && wrap_armed_r) begin
      wrap_nxt       = 1'b0; // R9
      wrap_armed_nxt = 1'b0;
    end
    if (wrap_ev) begin
      wrap_nxt = 1'b1; // R7
    end
  end

  // Timer interrupt: stays pending in the flags until unmasked
  always_comb begin
    irq_nxt = ~irq_mask_i &
              ((wrap_r & wrap_irq_enable_i) |                     // R8
               ((cap1.flag | cap2.flag) & capture_irq_enable_i)); // R17 R18
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wrap_r       <= 1'b0;
      wrap_armed_r <= 1'b0;
      irq_r        <= 1'b0;
    end else if (ce_i) begin
      wrap_r       <= wrap_nxt;
      wrap_armed_r <= wrap_armed_nxt;
      irq_r        <= irq_nxt;
    end
  end

  // Capture channel hookup; pins are never gated by their direction
  assign cap1.count     = cnt_r;
  assign cap1.edge_rise = capture_edge_select_i[0]; // R16
  assign cap1.enable    = ~(single_pulse_mode_i | pwm_mode_i); // R21
  assign cap1.rd_high   = acc_rd_i & (acc_sel_i == TCIC_SEL_CAP1_HI);
  assign cap1.rd_low    = (acc_rd_i | acc_wr_i) &
                          (acc_sel_i == TCIC_SEL_CAP1_LO);
  assign cap1.stat_rd   = stat_rd;
  assign cap2.count     = cnt_r;
  assign cap2.edge_rise = capture_edge_select_i[1]; // R16
  assign cap2.enable    = 1'b1; // R21
  assign cap2.rd_high   = acc_rd_i & (acc_sel_i == TCIC_SEL_CAP2_HI);
  assign cap2.rd_low    = (acc_rd_i | acc_wr_i) &
                          (acc_sel_i == TCIC_SEL_CAP2_LO);
  assign cap2.stat_rd   = stat_rd;

  tcic_capture u_cap_one (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .pin_i     (capture_pin_one_i),
    .cap       (cap1.chan)
  );

  tcic_capture u_cap_two (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .pin_i     (capture_pin_two_i),
    .cap       (cap2.chan)
  );

  // Outputs straight from flip-flops
  assign rd_data_o      = rd_data_r;
  assign count_o        = cnt_r;
  assign wrap_flag_o    = wrap_r;
  assign capture_flag_o = {cap2.flag, cap1.flag};
  assign timer_irq_o    = irq_r;

  a_reload_on_write: assert property (@(posedge clk_sys_i) // R2
    disable iff (!rst_b_i) ce_i && cnt_wr |=> cnt_r == 16'hfffc)
    else $error("counter not reloaded on low byte write");

  a_wrap_sets_flag: assert property (@(posedge clk_sys_i) // R7
    disable iff (!rst_b_i)
    ce_i && tick && !cnt_wr && cnt_r == 16'hffff |=> wrap_r && cnt_r == 16'h0)
    else $error("wrap did not set flag");

  a_shadow_keeps_wrap: assert property (@(posedge clk_sys_i) // R4
    disable iff (!rst_b_i)
    ce_i && wrap_r && (acc_rd_i || acc_wr_i) && acc_sel_i == TCIC_SEL_SHD_LO
    |=> wrap_r)
    else $error("shadow access cleared wrap flag");

  a_held_low_byte: assert property (@(posedge clk_sys_i) // R5
    disable iff (!rst_b_i)
    ce_i && rs_r == TCIC_RS_HELD && rd_lo |=> rd_data_r == $past(lo_buf_r))
    else $error("held low byte not returned");

  a_live_low_byte: assert property (@(posedge clk_sys_i) // R6
    disable iff (!rst_b_i)
    ce_i && rs_r == TCIC_RS_LIVE && rd_lo |=> rd_data_r == $past(cnt_r[7:0]))
    else $error("live low byte not returned");

  a_halt_freezes: assert property (@(posedge clk_sys_i) // R10
    disable iff (!rst_b_i)
    ce_i && halt_i && !cnt_wr |=> cnt_r == $past(cnt_r))
    else $error("counter moved in halt");

  a_ext_clock_only: assert property (@(posedge clk_sys_i) // R11
    disable iff (!rst_b_i)
    ce_i && clock_select_field_i == TCIC_CKS_EXT && !ext_edge && !cnt_wr
    |=> cnt_r == $past(cnt_r))
    else $error("counter moved without external edge");

  a_irq_masked: assert property (@(posedge clk_sys_i) // R8
    disable iff (!rst_b_i) ce_i && irq_mask_i |=> !timer_irq_o)
    else $error("interrupt raised while masked");

  a_irq_pending: assert property (@(posedge clk_sys_i) // R18
    disable iff (!rst_b_i)
    ce_i && !irq_mask_i && capture_irq_enable_i && cap2.flag |=> timer_irq_o)
    else $error("pending capture interrupt not raised");

endmodule

// [test/tcic_pin_model.sv]
// Purpose: Far-side pins: external clock and the two capture inputs
// Assumes: Called by the bench just after a rising clock edge
// Notes:   Each level is held long enough for the synchronisers
`timescale 1ns/100ps
module tcic_pin_model
  import tcic_pkg::*;
(
  input  wire logic       clk_sys_i,
  output logic            ext_clock_pin_o,
  output logic [1:0]      capture_pin_o
);
  // Pins idle low
  initial begin
    ext_clock_pin_o = 1'b0;
    capture_pin_o   = 2'h0;
  end

  // Move the external clock, then keep it still one clock past the least spacing
  task automatic ext_level(input logic lvl);
    ext_clock_pin_o = lvl;
    repeat (TCIC_EXT_MIN_CLKS + 1) @(posedge clk_sys_i);
    #1;
  endtask

  // Move one capture pin and let the capture land
  task automatic cap_level(input int ch, input logic lvl);
    capture_pin_o[ch] = lvl;
    repeat (TCIC_EXT_MIN_CLKS) @(posedge clk_sys_i);
    #1;
  endtask
endmodule

// [test/timer_counter_input_capture_tb.sv]
// Purpose: Self-checking bench of the timer with input capture
// Assumes: One-cycle access strobes; inputs move 1 ns after the edge
// Notes:   Halt freezes the count so captured values are known
`timescale 1ns/100ps
module timer_counter_input_capture_tb;
  import tcic_pkg::*;

  logic        clk_sys_i, rst_b_i, ce_i, halt_i, irq_mask_i;
  logic [1:0]  clock_select_field_i, capture_edge_select_i, cap_pin;
  logic        ext_edge_select_i, wrap_irq_enable_i, capture_irq_enable_i;
  logic        single_pulse_mode_i, pwm_mode_i, acc_rd_i, acc_wr_i;
  logic        ext_clock_pin_i, wrap_flag_o, timer_irq_o, pol;
  tcic_sel_t   acc_sel_i;
  logic [7:0]  rd_data_o;
  logic [15:0] count_o;
  logic [1:0]  capture_flag_o;
  int          n_errors, cmp_count, k, n, ch;

  tcic_timer dut_u (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .halt_i(halt_i), .irq_mask_i(irq_mask_i),
    .clock_select_field_i(clock_select_field_i),
    .ext_edge_select_i(ext_edge_select_i),
    .capture_edge_select_i(capture_edge_select_i),
    .wrap_irq_enable_i(wrap_irq_enable_i),
    .capture_irq_enable_i(capture_irq_enable_i),
    .single_pulse_mode_i(single_pulse_mode_i), .pwm_mode_i(pwm_mode_i),
    .ext_clock_pin_i(ext_clock_pin_i), .capture_pin_one_i(cap_pin[0]),
    .capture_pin_two_i(cap_pin[1]), .acc_rd_i(acc_rd_i),
    .acc_wr_i(acc_wr_i), .acc_sel_i(acc_sel_i), .rd_data_o(rd_data_o),
    .count_o(count_o), .wrap_flag_o(wrap_flag_o),
    .capture_flag_o(capture_flag_o), .timer_irq_o(timer_irq_o));

  tcic_pin_model pin_u (.clk_sys_i(clk_sys_i),
    .ext_clock_pin_o(ext_clock_pin_i), .capture_pin_o(cap_pin));

  // 40 MHz clock
  initial clk_sys_i = 1'b0;
  always #12.5 clk_sys_i = ~clk_sys_i;

  // Expected count after kk ticks from the reload value
  function automatic logic [15:0] exp_count(input int kk);
    return TCIC_CNT_RELOAD + 16'(kk);
  endfunction

  // Expected status byte
  function automatic logic [7:0] status_exp(input logic c1, w, c2);
    return {c1, 1'b0, w, c2, 4'h0};
  endfunction

  // Capture byte select of one channel
  function automatic tcic_sel_t cap_sel(input int c, input logic lo);
    if (c == 0) begin
      return lo ? TCIC_SEL_CAP1_LO : TCIC_SEL_CAP1_HI;
    end
    return lo ? TCIC_SEL_CAP2_LO : TCIC_SEL_CAP2_HI;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int cyc);
    repeat (cyc) @(posedge clk_sys_i);
    #1;
  endtask

  // One read or write strobe, then a quiet cycle
  task automatic acc(input logic wr, input tcic_sel_t sel);
    acc_sel_i = sel;
    acc_rd_i = ~wr;
    acc_wr_i = wr;
    step(1);
    acc_rd_i = 1'b0;
    acc_wr_i = 1'b0;
    step(1);
  endtask

  // Reload at divide by 2, let kk ticks pass, then halt
  task automatic freeze(input int kk);
    clock_select_field_i = TCIC_CKS_DIV2;
    halt_i = 1'b0;
    acc_sel_i = TCIC_SEL_CNT_LO;
    acc_wr_i = 1'b1;
    step(1);
    acc_wr_i = 1'b0;
    step(2 * kk);
    halt_i = 1'b1;
    step(1);
    chk(count_o, exp_count(kk));
  endtask

  task automatic pulse(input int c);
    pin_u.cap_level(c, 1'b1);
    pin_u.cap_level(c, 1'b0);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #(25 * 8000);
    n_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    {rst_b_i, halt_i, irq_mask_i, ext_edge_select_i, pwm_mode_i} = 5'h0;
    {wrap_irq_enable_i, capture_irq_enable_i, single_pulse_mode_i} = 3'h0;
    {acc_rd_i, acc_wr_i, capture_edge_select_i} = 4'h0;
    ce_i = 1'b1;
    clock_select_field_i = TCIC_CKS_DIV2;
    acc_sel_i = TCIC_SEL_CNT_HI;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(32'hd825));
    step(3);
    rst_b_i = 1'b1;
    chk(count_o, TCIC_CNT_RELOAD);
    chk({wrap_flag_o, capture_flag_o, timer_irq_o}, 16'h0);
    // Every internal ratio: four ticks from the reload reach the wrap
    for (int i = 0; i < 3; i++) begin
      n = 2 << i;
      clock_select_field_i = (i == 0) ? TCIC_CKS_DIV2 :
                             (i == 1) ? TCIC_CKS_DIV4 : TCIC_CKS_DIV8;
      acc(0, TCIC_SEL_STATUS);
      acc(1, (i == 0) ? TCIC_SEL_SHD_LO : TCIC_SEL_CNT_LO);
      step(4 * n - n / 2 - 1);
      chk(count_o, TCIC_CNT_TOP);
      chk(wrap_flag_o, 1'b0);
      step(n);
      chk(count_o, 16'h0000);
      chk(wrap_flag_o, 1'b1);
    end
    // Clearing needs a status read first; the shadow view never clears
    acc(0, TCIC_SEL_CNT_LO);
    chk(wrap_flag_o, 1'b1);
    acc(0, TCIC_SEL_STATUS);
    chk(rd_data_o, status_exp(1'b0, 1'b1, 1'b0));
    acc(0, TCIC_SEL_SHD_LO);
    chk(wrap_flag_o, 1'b1);
    acc(0, TCIC_SEL_CNT_LO);
    chk(wrap_flag_o, 1'b0);
    // Wrap interrupt waits for the enable and an open mask
    wrap_irq_enable_i = 1'b1;
    irq_mask_i = 1'b1;
    freeze(3);
    halt_i = 1'b0;
    step(2);
    halt_i = 1'b1;
    step(2);
    chk({wrap_flag_o, timer_irq_o}, 2'h2);
    irq_mask_i = 1'b0;
    step(2);
    chk(timer_irq_o, 1'b1);
    wrap_irq_enable_i = 1'b0;
    step(2);
    chk(timer_irq_o, 1'b0);
    acc(0, TCIC_SEL_STATUS);
    acc(0, TCIC_SEL_CNT_LO);
    // High byte first buffers the low byte; halt holds the count
    k = $urandom_range(2, 0);
    freeze(k);
    acc(0, TCIC_SEL_CNT_HI);
    chk(rd_data_o, 8'hff);
    halt_i = 1'b0;
    step(2);
    halt_i = 1'b1;
    step(10);
    chk(count_o, exp_count(k + 1));
    acc(0, TCIC_SEL_SHD_HI);
    chk(rd_data_o, 8'hff);
    acc(0, TCIC_SEL_CNT_LO);
    chk(rd_data_o, exp_count(k) & 16'h00ff);
    acc(0, TCIC_SEL_SHD_LO);
    chk(rd_data_o, exp_count(k + 1) & 16'h00ff);
    // Clock enable low freezes the count and ignores a reload write
    ce_i = 1'b0;
    halt_i = 1'b0;
    acc(1, TCIC_SEL_CNT_LO);
    step(6);
    chk(count_o, exp_count(k + 1));
    ce_i = 1'b1;
    halt_i = 1'b1;
    rst_b_i = 1'b0;
    step(1);
    rst_b_i = 1'b1;
    chk(count_o, TCIC_CNT_RELOAD);
    // Both channels, both edges: capture, flag, interrupt, lock, clear
    capture_irq_enable_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ch = i % 2;
      pol = (i > 1);
      k = $urandom_range(2, 0);
      freeze(k);
      irq_mask_i = pol;
      capture_edge_select_i[ch] = pol;
      pin_u.cap_level(ch, 1'b1);
      chk(capture_flag_o[ch], pol);
      pin_u.cap_level(ch, 1'b0);
      step(1);
      chk(timer_irq_o, !pol);
      acc(0, TCIC_SEL_STATUS);
      chk(rd_data_o, status_exp(ch == 0, 1'b0, ch == 1));
      acc(0, cap_sel(ch, 1'b0));
      chk(rd_data_o, 8'hff);
      acc(0, cap_sel(ch, 1'b1));
      chk(rd_data_o, exp_count(k) & 16'h00ff);
      chk(capture_flag_o, 2'h0);
      acc(0, cap_sel(ch, 1'b0));
      pulse(ch);
      chk(capture_flag_o[ch], 1'b0);
      acc(0, cap_sel(ch, 1'b1));
      freeze(k + 1);
      pulse(ch);
      acc(0, cap_sel(ch, 1'b1));
      chk(capture_flag_o[ch], 1'b1);
      chk(rd_data_o, exp_count(k + 1) & 16'h00ff);
      acc(0, TCIC_SEL_STATUS);
      acc(0, cap_sel(ch, 1'b1));
    end
    // Single pulse and PWM modes leave only channel two capturing
    capture_edge_select_i = 2'h3;
    irq_mask_i = 1'b0;
    for (int m = 0; m < 2; m++) begin
      single_pulse_mode_i = (m == 0);
      pwm_mode_i = (m == 1);
      capture_irq_enable_i = (m == 1);
      pulse(0);
      pulse(1);
      chk(capture_flag_o, 2'h2);
      chk(timer_irq_o, m == 1);
      acc(0, TCIC_SEL_STATUS);
      acc(0, TCIC_SEL_CAP2_LO);
    end
    single_pulse_mode_i = 1'b0;
    pwm_mode_i = 1'b0;
    // External clock: one tick per active edge of the chosen kind
    halt_i = 1'b0;
    clock_select_field_i = TCIC_CKS_EXT;
    for (int p = 0; p < 2; p++) begin
      ext_edge_select_i = p[0];
      acc(1, TCIC_SEL_CNT_LO);
      n = $urandom_range(5, 1);
      repeat (n) begin
        pin_u.ext_level(1'b1);
        pin_u.ext_level(1'b0);
      end
      chk(count_o, exp_count(n));
      pin_u.ext_level(1'b1);
      chk(count_o, exp_count(n + p));
      pin_u.ext_level(1'b0);
    end
    print_verdict();
  end
endmodule
